// file: rtl/nwf_pkg.sv
// Constants and types shared by the network word value formatter.
// Assumes a single 250 MHz clock and no software-visible registers.
package nwf_pkg;

  localparam int unsigned NWF_WORD_W   = 16;
  localparam int unsigned NWF_VAL_W    = 32;
  localparam int unsigned NWF_REM_W    = 10;
  localparam int unsigned NWF_CNT_W    = 5;

  // Split point of the decimal format
  localparam logic [31:0] NWF_DEC_BASE  = 32'h0000_03E8;
  // Decimal format limits, -32,768,000 and 32,767,999
  localparam logic [31:0] NWF_DEC_MIN   = 32'hFE0C_0000;
  localparam logic [31:0] NWF_DEC_MAX   = 32'h01F3_FFFF;
  // Last iteration index of the divider
  localparam logic [4:0]  NWF_DIV_LAST  = 5'h1F;
  // Cycles from an accepted decimal request to its answer
  localparam int unsigned NWF_DEC_LAT   = 35;

  localparam logic [31:0] NWF_RST_VAL   = 32'h0000_0000;
  localparam logic [15:0] NWF_RST_WORD  = 16'h0000;

  typedef enum logic {
    NWF_FMT_DEC = 1'b0,
    NWF_FMT_BIN = 1'b1
  } nwf_fmt_t;

  typedef enum logic {
    NWF_ORD_LITTLE = 1'b0,
    NWF_ORD_BIG    = 1'b1
  } nwf_order_t;

  typedef enum logic [1:0] {
    NWF_ST_IDLE = 2'b00,
    NWF_ST_DIV  = 2'b01
  } nwf_state_t;

endpackage

// file: rtl/nwf_div1k.sv
// Sequential unsigned divider by the decimal split base.
// Assumes start is a one-cycle pulse given only while idle.
`timescale 1ns/1ns
module nwf_div1k
  import nwf_pkg::*;
(
  input  wire logic                           ref_clk,
  input  wire logic                           rst_b,
  input  wire logic                           start,
  input  wire logic [nwf_pkg::NWF_VAL_W-1:0]  dividend,
  output logic      [nwf_pkg::NWF_VAL_W-1:0]  quot,
  output logic      [nwf_pkg::NWF_REM_W-1:0]  rem,
  output logic                                done
);

  typedef struct packed {
    logic                 busy;
    logic [NWF_CNT_W-1:0] cnt;
    logic [NWF_VAL_W-1:0] q;
    logic [NWF_REM_W:0]   r;
    logic                 done;
  } nwf_div_st_t;

  nwf_div_st_t s_ff;
  nwf_div_st_t nxt_s;

  always_comb begin
    logic [NWF_REM_W:0] trial;
    trial      = '0;
    nxt_s      = s_ff;
    nxt_s.done = 1'b0;
    if (start && !s_ff.busy) begin
      nxt_s.busy = 1'b1;
      nxt_s.cnt  = '0;
      nxt_s.q    = dividend;
      nxt_s.r    = '0;
    end else if (s_ff.busy) begin
      // Restoring step: shift in one dividend bit
      trial     = {s_ff.r[NWF_REM_W-1:0], s_ff.q[NWF_VAL_W-1]};
      nxt_s.q   = {s_ff.q[NWF_VAL_W-2:0], 1'b0};
      if (trial >= NWF_DEC_BASE[NWF_REM_W:0]) begin
        trial      = trial - NWF_DEC_BASE[NWF_REM_W:0];
        nxt_s.q[0] = 1'b1;
      end
      nxt_s.r   = trial;
      nxt_s.cnt = s_ff.cnt + 5'h01;
      if (s_ff.cnt == NWF_DIV_LAST) begin
        nxt_s.busy = 1'b0;
        nxt_s.done = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign quot = s_ff.q;
  assign rem  = s_ff.r[NWF_REM_W-1:0];
  assign done = s_ff.done;

endmodule

// file: rtl/nwf_formatter.sv
// Network word value formatter: 32-bit values to and from word pairs.
// Assumes format and word order inputs are steady around each request.
`timescale 1ns/1ns
// Operation
// - Every value travels in 16-bit words, a wide value in a pair of consecutive words.
// - Decimal format puts the thousands and above in the lower word and the last three digits in the higher word.
// - Decimal format covers -32,768,000 to 32,767,999 inclusive.
// - A value outside the decimal range may leave the two words undefined.
// - Binary format carries the value as a two's-complement number across both words.
// - In binary format little order puts the low half in the lower word, big order the high half.
// - Binary values go back to the host in the same word order the host writes them.
// - Read and write directions each have their own format selection.
module nwf_formatter
  import nwf_pkg::*;
(
  input  wire logic                             ref_clk,
  input  wire logic                             rst_b,
  input  wire nwf_pkg::nwf_fmt_t                rd_fmt,
  input  wire nwf_pkg::nwf_fmt_t                wr_fmt,
  input  wire nwf_pkg::nwf_order_t              word_order,
  input  wire logic                             enc_req,
  input  wire logic [nwf_pkg::NWF_VAL_W-1:0]    enc_value,
  output logic                                  enc_busy,
  output logic                                  enc_valid,
  output logic      [nwf_pkg::NWF_WORD_W-1:0]   enc_word0,
  output logic      [nwf_pkg::NWF_WORD_W-1:0]   enc_word1,
  output logic                                  enc_range_err,
  input  wire logic                             dec_req,
  input  wire logic [nwf_pkg::NWF_WORD_W-1:0]   dec_word0,
  input  wire logic [nwf_pkg::NWF_WORD_W-1:0]   dec_word1,
  output logic                                  dec_valid,
  output logic      [nwf_pkg::NWF_VAL_W-1:0]    dec_value
);

  typedef struct packed {
    nwf_state_t            state;
    logic                  busy;
    logic                  div_start;
    logic [NWF_VAL_W-1:0]  src;
    logic                  src_dec;
    logic                  enc_vld;
    logic [NWF_WORD_W-1:0] w0;
    logic [NWF_WORD_W-1:0] w1;
    logic                  range_err;
    logic                  dec_vld;
    logic [NWF_VAL_W-1:0]  dec_val;
  } nwf_st_t;

  nwf_st_t                s_ff;
  nwf_st_t                nxt_s;
  logic [NWF_VAL_W-1:0]   mag;
  logic [NWF_VAL_W-1:0]   div_quot;
  logic [NWF_REM_W-1:0]   div_rem;
  logic                   div_done;

  // Magnitude of the held value feeds the divider
  assign mag = s_ff.src[NWF_VAL_W-1] ? (NWF_VAL_W)'(-s_ff.src) : s_ff.src;

  nwf_div1k u_div (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .start    (s_ff.div_start),
    .dividend (mag),
    .quot     (div_quot),
    .rem      (div_rem),
    .done     (div_done)
  );

  always_comb begin
    logic [NWF_WORD_W-1:0] th;
    logic [NWF_WORD_W-1:0] rm;
    logic signed [31:0]    d0;
    logic signed [31:0]    d1;
    th              = '0;
    rm              = '0;
    d0              = '0;
    d1              = '0;
    nxt_s           = s_ff;
    nxt_s.enc_vld   = 1'b0;
    nxt_s.dec_vld   = 1'b0;
    nxt_s.div_start = 1'b0;
    case (s_ff.state)
      NWF_ST_IDLE: begin
        if (enc_req) begin
          nxt_s.src     = enc_value;
          nxt_s.src_dec = (rd_fmt == NWF_FMT_DEC);
          if (rd_fmt == NWF_FMT_BIN) begin
            // Two's-complement halves, order from the shared setting
            if (word_order == NWF_ORD_BIG) begin
              nxt_s.w0 = enc_value[31:16];
              nxt_s.w1 = enc_value[15:0];
            end else begin
              nxt_s.w0 = enc_value[15:0];
              nxt_s.w1 = enc_value[31:16];
            end
            nxt_s.range_err = 1'b0;
            nxt_s.enc_vld   = 1'b1;
          end else begin
            nxt_s.state     = NWF_ST_DIV;
            nxt_s.busy      = 1'b1;
            nxt_s.div_start = 1'b1;
          end
        end
      end
      NWF_ST_DIV: begin
        if (div_done) begin
          th = div_quot[NWF_WORD_W-1:0];
          rm = {6'h00, div_rem};
          // Sign goes to both words
          if (s_ff.src[NWF_VAL_W-1]) begin
            th = (NWF_WORD_W)'(-th);
            rm = (NWF_WORD_W)'(-rm);
          end
          nxt_s.w0        = th;
          nxt_s.w1        = rm;
          // Words are undefined when flagged
          nxt_s.range_err = ($signed(s_ff.src) < $signed(NWF_DEC_MIN)) ||
                            ($signed(s_ff.src) > $signed(NWF_DEC_MAX));
          nxt_s.enc_vld   = 1'b1;
          nxt_s.busy      = 1'b0;
          nxt_s.state     = NWF_ST_IDLE;
        end
      end
      default: begin
        nxt_s.state = NWF_ST_IDLE;
        nxt_s.busy  = 1'b0;
      end
    endcase
    // Host-written words, independent of the read path
    if (dec_req) begin
      if (wr_fmt == NWF_FMT_BIN) begin
        if (word_order == NWF_ORD_BIG) begin
          nxt_s.dec_val = {dec_word0, dec_word1};
        end else begin
          nxt_s.dec_val = {dec_word1, dec_word0};
        end
      end else begin
        d0            = {{16{dec_word0[15]}}, dec_word0};
        d1            = {{16{dec_word1[15]}}, dec_word1};
        nxt_s.dec_val = 32'(d0 * $signed(NWF_DEC_BASE) + d1);
      end
      nxt_s.dec_vld = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_ff       <= '0;
      s_ff.state <= NWF_ST_IDLE;
      s_ff.src   <= NWF_RST_VAL;
      s_ff.w0    <= NWF_RST_WORD;
      s_ff.w1    <= NWF_RST_WORD;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign enc_busy      = s_ff.busy;
  assign enc_valid     = s_ff.enc_vld;
  assign enc_word0     = s_ff.w0;
  assign enc_word1     = s_ff.w1;
  assign enc_range_err = s_ff.range_err;
  assign dec_valid     = s_ff.dec_vld;
  assign dec_value     = s_ff.dec_val;

  // Checks
  logic signed [31:0] recon;
  assign recon = 32'($signed({{16{s_ff.w0[15]}}, s_ff.w0}) * $signed(NWF_DEC_BASE) +
                     $signed({{16{s_ff.w1[15]}}, s_ff.w1}));

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_bin_req(nwf_order_t o);
    enc_req && !s_ff.busy && rd_fmt == NWF_FMT_BIN && word_order == o;
  endsequence

  sequence s_dec_req;
    enc_req && !s_ff.busy && rd_fmt == NWF_FMT_DEC;
  endsequence

  property p_bin_little;
    s_bin_req(NWF_ORD_LITTLE) |=> enc_valid && enc_word0 == $past(enc_value[15:0]) &&
                                   enc_word1 == $past(enc_value[31:16]);
  endproperty
  a_bin_little: assert property (p_bin_little) else $error("little order words wrong");

  property p_bin_big;
    s_bin_req(NWF_ORD_BIG) |=> enc_valid && enc_word0 == $past(enc_value[31:16]) &&
                                enc_word1 == $past(enc_value[15:0]);
  endproperty
  a_bin_big: assert property (p_bin_big) else $error("big order words wrong");

  // Busy at the first and last working cycle of a decimal conversion
  sequence s_dec_busy;
    enc_busy ##33 enc_busy;
  endsequence

  property p_dec_latency;
    s_dec_req |-> ##1 s_dec_busy ##1 (enc_valid && !enc_busy);
  endproperty
  a_dec_latency: assert property (p_dec_latency) else $error("decimal answer not on time");

  // Busy only ends together with an answer, so it cannot dip mid-conversion
  property p_busy_end;
    enc_busy ##1 !enc_busy |-> enc_valid;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy dropped without an answer");

  property p_dec_split;
    enc_valid && s_ff.src_dec && !enc_range_err |-> recon == $signed(s_ff.src);
  endproperty
  a_dec_split: assert property (p_dec_split) else $error("decimal words do not rebuild value");

  property p_dec_rem;
    enc_valid && s_ff.src_dec && !enc_range_err |->
      ($signed(enc_word1) < 16'sd1000) && ($signed(enc_word1) > -16'sd1000) &&
      (s_ff.src[31] || (!enc_word0[15] && !enc_word1[15]));
  endproperty
  a_dec_rem: assert property (p_dec_rem) else $error("remainder word out of form");

  property p_range;
    enc_valid && s_ff.src_dec |-> enc_range_err == (($signed(s_ff.src) < $signed(NWF_DEC_MIN)) ||
                                                    ($signed(s_ff.src) > $signed(NWF_DEC_MAX)));
  endproperty
  a_range: assert property (p_range) else $error("range flag wrong");

  property p_wr_bin;
    dec_req && wr_fmt == NWF_FMT_BIN && word_order == NWF_ORD_LITTLE |=>
      dec_valid && dec_value == {$past(dec_word1), $past(dec_word0)};
  endproperty
  a_wr_bin: assert property (p_wr_bin) else $error("binary write value wrong");

  property p_wr_dec;
    dec_req && wr_fmt == NWF_FMT_DEC |=>
      dec_valid && $signed(dec_value) == 32'($signed({{16{$past(dec_word0[15])}}, $past(dec_word0)}) *
                   $signed(NWF_DEC_BASE) + $signed({{16{$past(dec_word1[15])}}, $past(dec_word1)}));
  endproperty
  a_wr_dec: assert property (p_wr_dec) else $error("decimal write value wrong");

endmodule

// file: dv/nwf_host_model.sv
// Host controller model: holds format and word order, writes value word pairs.
// Assumes the formatter samples its inputs on the rising edge of ref_clk.
`timescale 1ns/1ns
module nwf_host_model
  import nwf_pkg::*;
(
  input  wire logic                           ref_clk,
  output nwf_pkg::nwf_fmt_t                   rd_fmt,
  output nwf_pkg::nwf_fmt_t                   wr_fmt,
  output nwf_pkg::nwf_order_t                 word_order,
  output logic                                dec_req,
  output logic [nwf_pkg::NWF_WORD_W-1:0]      dec_word0,
  output logic [nwf_pkg::NWF_WORD_W-1:0]      dec_word1
);
  initial begin
    rd_fmt     = NWF_FMT_DEC;
    wr_fmt     = NWF_FMT_DEC;
    word_order = NWF_ORD_LITTLE;
    dec_req    = 1'b0;
    dec_word0  = 16'h0000;
    dec_word1  = 16'h0000;
  end

  task automatic cfg(input nwf_fmt_t rf, input nwf_fmt_t wf, input nwf_order_t o);
    @(posedge ref_clk);
    #1;
    rd_fmt     = rf;
    wr_fmt     = wf;
    word_order = o;
  endtask

  // Returns just after the taking edge
  task automatic put(input logic [31:0] v);
    logic [15:0] a;
    logic [15:0] b;
    int          s;
    s = v;
    if (wr_fmt == NWF_FMT_BIN) begin
      {a, b} = (word_order == NWF_ORD_LITTLE) ? {v[15:0], v[31:16]} : v;
    end else begin
      a = 16'(s / 1000);
      b = 16'(s % 1000);
    end
    @(posedge ref_clk);
    #1;
    dec_req   = 1'b1;
    dec_word0 = a;
    dec_word1 = b;
    @(posedge ref_clk);
    #1;
    // Released words show the inverse, not a stale copy
    dec_req   = 1'b0;
    dec_word0 = ~a;
    dec_word1 = ~b;
  endtask
endmodule

// file: dv/nwf_formatter_test.sv
// Testbench for the network word value formatter, scenario tasks.
// Assumes the host model drives format, word order and the decode side.
`timescale 1ns/1ns
module nwf_formatter_test;
  import nwf_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  nwf_fmt_t    rd_fmt;
  nwf_fmt_t    wr_fmt;
  nwf_order_t  word_order;
  logic        enc_req = 1'b0;
  logic [31:0] enc_value = 32'h0000_0000;
  logic        enc_busy;
  logic        enc_valid;
  logic [15:0] enc_word0;
  logic [15:0] enc_word1;
  logic        enc_range_err;
  logic        dec_req;
  logic [15:0] dec_word0;
  logic [15:0] dec_word1;
  logic        dec_valid;
  logic [31:0] dec_value;
  int          fails = 0;
  int          n_compared = 0;
  int          dv[6] = '{12345, -12345, 32767999, -32768000, 0, -999};
  logic [31:0] bv[3] = '{32'h0001_E240, 32'hFFFE_1DBF, 32'h8000_0001};

  nwf_host_model host (.ref_clk(ref_clk), .rd_fmt(rd_fmt), .wr_fmt(wr_fmt), .word_order(word_order),
    .dec_req(dec_req), .dec_word0(dec_word0), .dec_word1(dec_word1));
  nwf_formatter uut (.ref_clk(ref_clk), .rst_b(rst_b), .rd_fmt(rd_fmt), .wr_fmt(wr_fmt),
    .word_order(word_order), .enc_req(enc_req), .enc_value(enc_value), .enc_busy(enc_busy),
    .enc_valid(enc_valid), .enc_word0(enc_word0), .enc_word1(enc_word1),
    .enc_range_err(enc_range_err), .dec_req(dec_req), .dec_word0(dec_word0),
    .dec_word1(dec_word1), .dec_valid(dec_valid), .dec_value(dec_value));

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic chk(input bit ok, input string m);
    n_compared++;
    if (!ok) begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Encode one value; in decimal format a refused request is slipped in while busy
  task automatic enc(input logic [31:0] v);
    int          n;
    int          s;
    bit          d;
    bit          err;
    logic [31:0] e;
    s   = v;
    d   = (rd_fmt == NWF_FMT_DEC);
    err = d && (s < -32768000 || s > 32767999);
    e   = d ? {16'(s / 1000), 16'(s % 1000)} :
          ((word_order == NWF_ORD_LITTLE) ? {v[15:0], v[31:16]} : v);
    @(posedge ref_clk);
    #1;
    enc_req   = 1'b1;
    enc_value = v;
    @(posedge ref_clk);
    #1;
    enc_req = 1'b0;
    n = 1;
    while (enc_valid !== 1'b1 && n < 60) begin
      if (n == 5) begin
        chk(enc_busy === 1'b1, "busy low during decimal work");
        enc_req   = 1'b1;
        enc_value = ~v;
      end else begin
        enc_req = 1'b0;
      end
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(n == (d ? 35 : 1), "encode latency");
    chk(enc_range_err === err, "range flag");
    if (!err) chk({enc_word0, enc_word1} === e, "encoded words");
    @(posedge ref_clk);
    #1;
    chk(enc_valid === 1'b0 && enc_busy === 1'b0, "valid not a single pulse");
  endtask

  task automatic dec(input logic [31:0] v);
    host.put(v);
    chk(dec_valid === 1'b1 && dec_value === v, "decoded value");
  endtask

  task automatic t_reset();
    chk({enc_busy, enc_valid, enc_word0, enc_word1, enc_range_err, dec_valid, dec_value} === '0, "reset");
    $display("test reset done");
  endtask

  task automatic t_binary();
    for (int o = 0; o < 2; o++) begin
      host.cfg(NWF_FMT_BIN, NWF_FMT_BIN, nwf_order_t'(o));
      foreach (bv[i]) begin
        enc(bv[i]);
        dec(bv[i]);
      end
    end
    $display("test binary done");
  endtask

  task automatic t_decimal();
    host.cfg(NWF_FMT_DEC, NWF_FMT_DEC, NWF_ORD_BIG);
    foreach (dv[i]) begin
      enc(dv[i]);
      dec(dv[i]);
    end
    enc(32'h01F4_0000);
    enc(32'hFE0B_FFFF);
    $display("test decimal done");
  endtask

  task automatic t_split();
    host.cfg(NWF_FMT_BIN, NWF_FMT_DEC, NWF_ORD_BIG);
    enc(32'h0000_3039);
    dec(32'h0000_3039);
    host.cfg(NWF_FMT_DEC, NWF_FMT_BIN, NWF_ORD_LITTLE);
    enc(32'h0000_3039);
    dec(32'h0001_E240);
    $display("test split formats done");
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    t_reset();
    t_binary();
    t_decimal();
    t_split();
    conclude();
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end
endmodule
